// ---- shared/hcr_defs.svh ----
// Constants of the hub class request handler and its host end
`ifndef HCR_DEFS_SVH
`define HCR_DEFS_SVH
`define HCR_NPORTS 4
`define HCR_PW 3
`define HCR_RT_HUB 8'h20
`define HCR_RT_PORT 8'h23
`define HCR_REQ_SET_FEATURE 8'h03
`define HCR_REQ_SET_DESC 8'h07
`define HCR_REQ_STOP_TT 8'h0b
`define HCR_DESC_TYPE 8'h29
`define HCR_DESC_INDEX 8'h00
`define HCR_DESC_MAX 16'h0010
`define HCR_HF_LAST 16'h0001
`define HCR_PF_SUSPEND 8'h02
`define HCR_PF_RESET 8'h04
`define HCR_PF_POWER 8'h08
`define HCR_PF_C_FIRST 8'h10
`define HCR_PF_C_LAST 8'h14
`define HCR_PF_TEST 8'h15
`define HCR_PF_INDICATOR 8'h16
`define HCR_TEST_FIRST 8'h01
`define HCR_TEST_LAST 8'h05
`define HCR_IND_LAST 8'h03
`define HCR_CLK_MHZ 250
`define HCR_RESET_SIG_NS 200
`define HCR_RESET_SIG_CYC 8'(((`HCR_RESET_SIG_NS * `HCR_CLK_MHZ) + 999) / 1000)
`define HCR_A_REQ 3'h0
`define HCR_A_VALUE 3'h1
`define HCR_A_INDEX 3'h2
`define HCR_A_LENGTH 3'h3
`define HCR_A_DATA 3'h4
`define HCR_A_CTRL 3'h5
`define HCR_A_STAT 3'h6
`endif

// ---- shared/hcr_if.sv ----
// Control transfer link between the host end and the hub end
`timescale 1ns/1ps
interface hcr_if;
    import hcr_pkg::*;
    logic        setup;
    logic [7:0]  bm_req_type;
    logic [7:0]  b_request;
    logic [15:0] w_value;
    logic [15:0] w_index;
    logic [15:0] w_length;
    logic        data_valid;
    logic [7:0]  data_byte;
    logic        status;
    logic        resp_valid;
    hcr_res_t    resp_code;
    modport dev (input setup, bm_req_type, b_request, w_value, w_index, w_length,
                 input data_valid, data_byte, status, output resp_valid, resp_code);
    modport host (output setup, bm_req_type, b_request, w_value, w_index, w_length,
                  output data_valid, data_byte, status, input resp_valid, resp_code);
endinterface

// ---- shared/hcr_pkg.sv ----
// Types shared by both ends of the hub class request link
package hcr_pkg;
    typedef enum logic [1:0] {RES_OK = 2'b00, RES_REQ_ERR = 2'b01, RES_STALL = 2'b10} hcr_res_t;
    typedef enum logic [1:0] {OP_NONE = 2'b00, OP_DESC = 2'b01, OP_STOP_TT = 2'b10, OP_PORT = 2'b11} hcr_op_t;
    typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_DATA = 2'b01, DS_STALL = 2'b10} hcr_dev_st_t;
    typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_DATA = 2'b01, HS_WAIT = 2'b10} hcr_host_st_t;
endpackage

// ---- src/hcr_desc_buf.sv ----
// Staging buffer and live copy of the hub descriptor
`timescale 1ns/1ps
`include "hcr_defs.svh"
module hcr_desc_buf (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Staging side
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       commit,
    // Live side
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data
);
    logic [7:0] stage_reg [`HCR_DESC_MAX];
    logic [7:0] live_reg  [`HCR_DESC_MAX];

    // Live copy changes only on commit
    for (genvar e = 0; e < `HCR_DESC_MAX; e++) begin : g_entry
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                stage_reg[e] <= 8'h00;
            end else if (wr_en && wr_addr == 4'(e)) begin
                stage_reg[e] <= wr_data;
            end
        end
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                live_reg[e] <= 8'h00;
            end else if (commit) begin
                live_reg[e] <= stage_reg[e];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= live_reg[rd_addr];
        end
    end
endmodule

// ---- src/hcr_device.sv ----
// Hub end: decodes and carries out hub class set requests
//
// How it works
// - Descriptor write, type 20h, replaces descriptor
// - Only hub descriptor index zero exists
// - Buffer bytes, commit after whole transfer
// - Nonzero wIndex or length mismatch errs
// - Unsupported descriptor write stalls data stage
// - Translator stop, type 23h, halts translator
// - Only translator reset restarts stopped translator
// - Single translator ignores port; wLength nonzero errs
// - Hub feature set enables selected feature; here accepted, nothing set
// - Unknown hub selector or nonzero fields err
// - Port in wIndex low byte, nonzero, valid
// - Accept reset, suspend, power, test, indicator
// - Suspend stops traffic on that port
// - Reset signalling, then change bit and enable
// - Test selector in wIndex high byte
// - Test selectors one to five only valid
// - Test needs enabled ports suspended, one at time
// - Other ports report disconnect/resume during test
// - Host sends nothing but status reads in test
// - Host resets hub through parent after test
// - Indicator selector zero to three, else error
// - Reset/suspend/power no-op in wrong port state
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "hcr_defs.svh"
module hcr_device
    import hcr_pkg::*;
#(
    parameter bit DESC_WRITE_EN = 1'b1
) (
    // Link to the host
    hcr_if.dev                    LNK,
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    // Port state and events
    input  wire logic [`HCR_NPORTS-1:0] PORT_ENABLED,
    input  wire logic [`HCR_NPORTS-1:0] PORT_DISCONNECT,
    input  wire logic [`HCR_NPORTS-1:0] PORT_RESUME,
    // Change bit acknowledges
    input  wire logic [`HCR_NPORTS-1:0] CLR_C_RESET,
    input  wire logic [`HCR_NPORTS-1:0] CLR_C_CONN,
    input  wire logic [`HCR_NPORTS-1:0] CLR_C_SUSP,
    // Port controls
    output logic      [`HCR_NPORTS-1:0] PORT_POWER,
    output logic      [`HCR_NPORTS-1:0] PORT_RESET_DRV,
    output logic      [`HCR_NPORTS-1:0] PORT_SUSPEND,
    output logic      [`HCR_NPORTS-1:0] PORT_ENABLE_SET,
    output logic      [`HCR_NPORTS-1:0] PORT_TEST_EN,
    output logic      [7:0]             TEST_SEL,
    output logic      [2*`HCR_NPORTS-1:0] IND_SEL,
    // Change bits
    output logic      [`HCR_NPORTS-1:0] C_PORT_RESET,
    output logic      [`HCR_NPORTS-1:0] C_PORT_CONN,
    output logic      [`HCR_NPORTS-1:0] C_PORT_SUSP,
    // Transaction translator
    input  wire logic             TT_RESET,
    output logic                  TT_STOPPED,
    // Descriptor readback
    input  wire logic [3:0]       DESC_ADDR,
    output logic      [7:0]       DESC_DATA,
    output logic                  DESC_UPDATED
);
    hcr_dev_st_t st_reg;
    hcr_op_t     op_reg;
    hcr_op_t     op_next;
    logic        err_reg;
    logic        err_next;
    logic [15:0] len_reg;
    logic [15:0] cnt_reg;
    logic [7:0]  sel_reg;
    logic [7:0]  hi_reg;
    logic [7:0]  pidx_reg;
    logic        resp_valid_reg;
    hcr_res_t    resp_code_reg;
    logic        done_ok;
    logic        any_test;
    logic        all_quiet;
    logic        port_ok;
    logic [7:0]  rt;
    logic [7:0]  rq;
    logic [7:0]  fsel;
    logic [7:0]  hi;

    assign LNK.resp_valid = resp_valid_reg;
    assign LNK.resp_code  = resp_code_reg;
    assign rt             = LNK.bm_req_type;
    assign rq             = LNK.b_request;
    assign fsel           = LNK.w_value[7:0];
    assign hi             = LNK.w_index[15:8];
    assign port_ok        = LNK.w_index[7:0] != 8'h00 && LNK.w_index[7:0] <= 8'(`HCR_NPORTS);
    assign any_test       = |PORT_TEST_EN;
    assign all_quiet      = ~|(PORT_ENABLED & ~PORT_SUSPEND);
    assign done_ok        = st_reg == DS_DATA && LNK.status && !err_reg && cnt_reg == len_reg;

    // Checks on the setup fields
    always_comb begin
        op_next  = OP_NONE;
        err_next = 1'b1;
        if (rt == `HCR_RT_HUB && rq == `HCR_REQ_SET_DESC) begin
            op_next  = OP_DESC;
            err_next = LNK.w_value != {`HCR_DESC_TYPE, `HCR_DESC_INDEX}
                       || LNK.w_index != 16'h0000
                       || LNK.w_length > `HCR_DESC_MAX;
        end else if (rt == `HCR_RT_PORT && rq == `HCR_REQ_STOP_TT) begin
            op_next  = OP_STOP_TT;
            err_next = LNK.w_value != 16'h0000 || LNK.w_length != 16'h0000;
        end else if (rt == `HCR_RT_HUB && rq == `HCR_REQ_SET_FEATURE) begin
            op_next  = OP_NONE;
            err_next = LNK.w_value > `HCR_HF_LAST || LNK.w_index != 16'h0000
                       || LNK.w_length != 16'h0000;
        end else if (rt == `HCR_RT_PORT && rq == `HCR_REQ_SET_FEATURE) begin
            op_next = OP_PORT;
            if (!port_ok || LNK.w_length != 16'h0000 || LNK.w_value[15:8] != 8'h00) begin
                err_next = 1'b1;
            end else begin
                case (fsel)
                    `HCR_PF_RESET, `HCR_PF_SUSPEND, `HCR_PF_POWER: begin
                        err_next = hi != 8'h00;
                    end
                    `HCR_PF_TEST: begin
                        err_next = hi < `HCR_TEST_FIRST || hi > `HCR_TEST_LAST
                                   || !all_quiet;
                    end
                    `HCR_PF_INDICATOR: begin
                        err_next = hi > `HCR_IND_LAST;
                    end
                    default: begin
                        // Change selectors are taken and ignored
                        err_next = fsel < `HCR_PF_C_FIRST || fsel > `HCR_PF_C_LAST || hi != 8'h00;
                    end
                endcase
            end
        end
        // Requests in test mode are refused until the hub is reset
        if (any_test) begin
            err_next = 1'b1;
        end
    end

    // Request sequence
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_reg   <= DS_IDLE;
            op_reg   <= OP_NONE;
            err_reg  <= 1'b0;
            len_reg  <= 16'h0000;
            sel_reg  <= 8'h00;
            hi_reg   <= 8'h00;
            pidx_reg <= 8'h00;
        end else begin
            case (st_reg)
                DS_IDLE: begin
                    if (LNK.setup) begin
                        op_reg   <= op_next;
                        err_reg  <= err_next;
                        len_reg  <= LNK.w_length;
                        sel_reg  <= fsel;
                        hi_reg   <= hi;
                        pidx_reg <= LNK.w_index[7:0];
                        st_reg   <= (op_next == OP_DESC && !DESC_WRITE_EN) ? DS_STALL : DS_DATA;
                    end
                end
                DS_DATA: begin
                    if (LNK.status) begin
                        st_reg <= DS_IDLE;
                    end
                end
                DS_STALL: begin
                    if (LNK.data_valid || LNK.status) begin
                        st_reg <= DS_IDLE;
                    end
                end
                default: begin
                    st_reg <= DS_IDLE;
                end
            endcase
        end
    end

    // Surplus data bytes are counted and also written to staging
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cnt_reg <= 16'h0000;
        end else if (st_reg == DS_IDLE) begin
            cnt_reg <= 16'h0000;
        end else if (st_reg == DS_DATA && LNK.data_valid && cnt_reg != 16'hffff) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // A stall answers the first data byte or status
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            resp_valid_reg <= 1'b0;
            resp_code_reg  <= RES_OK;
        end else begin
            resp_valid_reg <= 1'b0;
            if (st_reg == DS_STALL && (LNK.data_valid || LNK.status)) begin
                resp_valid_reg <= 1'b1;
                resp_code_reg  <= RES_STALL;
            end else if (st_reg == DS_DATA && LNK.status) begin
                resp_valid_reg <= 1'b1;
                resp_code_reg  <= done_ok ? RES_OK : RES_REQ_ERR;
            end
        end
    end

    hcr_desc_buf u_desc (
        .clk     (CLK),
        .reset_n (RESET_N),
        .wr_en   (st_reg == DS_DATA && op_reg == OP_DESC && LNK.data_valid),
        .wr_addr (cnt_reg[3:0]),
        .wr_data (LNK.data_byte),
        .commit  (done_ok && op_reg == OP_DESC),
        .rd_addr (DESC_ADDR),
        .rd_data (DESC_DATA)
    );

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            DESC_UPDATED <= 1'b0;
        end else begin
            DESC_UPDATED <= done_ok && op_reg == OP_DESC;
        end
    end

    // Only a translator reset restarts it
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            TT_STOPPED <= 1'b0;
        end else if (done_ok && op_reg == OP_STOP_TT) begin
            TT_STOPPED <= 1'b1;
        end else if (TT_RESET) begin
            TT_STOPPED <= 1'b0;
        end
    end

    // Test mode starts one cycle after status
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            TEST_SEL <= 8'h00;
        end else if (done_ok && op_reg == OP_PORT && sel_reg == `HCR_PF_TEST) begin
            TEST_SEL <= hi_reg;
        end
    end

    for (genvar i = 0; i < `HCR_NPORTS; i++) begin : g_port
        logic       hit;
        logic [7:0] rst_cnt_reg;

        assign hit = done_ok && op_reg == OP_PORT && pidx_reg == 8'(i + 1);

        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                PORT_POWER[i] <= 1'b0;
            end else if (hit && sel_reg == `HCR_PF_POWER) begin
                PORT_POWER[i] <= 1'b1;
            end
        end

        // Fixed-length reset; its end enables the port
        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                rst_cnt_reg        <= 8'h00;
                PORT_RESET_DRV[i]  <= 1'b0;
                PORT_ENABLE_SET[i] <= 1'b0;
            end else begin
                PORT_ENABLE_SET[i] <= 1'b0;
                if (hit && sel_reg == `HCR_PF_RESET && PORT_POWER[i]) begin
                    rst_cnt_reg       <= `HCR_RESET_SIG_CYC;
                    PORT_RESET_DRV[i] <= 1'b1;
                end else if (rst_cnt_reg == 8'h01) begin
                    rst_cnt_reg        <= 8'h00;
                    PORT_RESET_DRV[i]  <= 1'b0;
                    PORT_ENABLE_SET[i] <= 1'b1;
                end else if (rst_cnt_reg != 8'h00) begin
                    rst_cnt_reg <= rst_cnt_reg - 8'h01;
                end
            end
        end

        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                C_PORT_RESET[i] <= 1'b0;
            end else if (rst_cnt_reg == 8'h01) begin
                C_PORT_RESET[i] <= 1'b1;
            end else if (CLR_C_RESET[i]) begin
                C_PORT_RESET[i] <= 1'b0;
            end
        end

        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                PORT_SUSPEND[i] <= 1'b0;
            end else if (hit && sel_reg == `HCR_PF_SUSPEND && PORT_ENABLED[i]) begin
                PORT_SUSPEND[i] <= 1'b1;
            end else if (PORT_RESUME[i] || PORT_RESET_DRV[i]) begin
                PORT_SUSPEND[i] <= 1'b0;
            end
        end

        // Still reported while a port is in test
        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                C_PORT_CONN[i] <= 1'b0;
                C_PORT_SUSP[i] <= 1'b0;
            end else begin
                if (PORT_DISCONNECT[i]) begin
                    C_PORT_CONN[i] <= 1'b1;
                end else if (CLR_C_CONN[i]) begin
                    C_PORT_CONN[i] <= 1'b0;
                end
                if (PORT_RESUME[i] && PORT_SUSPEND[i]) begin
                    C_PORT_SUSP[i] <= 1'b1;
                end else if (CLR_C_SUSP[i]) begin
                    C_PORT_SUSP[i] <= 1'b0;
                end
            end
        end

        // Only a hub reset leaves test mode
        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                PORT_TEST_EN[i] <= 1'b0;
                IND_SEL[2*i+:2] <= 2'b00;
            end else begin
                if (hit && sel_reg == `HCR_PF_TEST) begin
                    PORT_TEST_EN[i] <= 1'b1;
                end
                if (hit && sel_reg == `HCR_PF_INDICATOR) begin
                    IND_SEL[2*i+:2] <= hi_reg[1:0];
                end
            end
        end
    end
endmodule

// ---- src/hcr_host.sv ----
// Host end: issues hub class control transfers ordered through local registers
`timescale 1ns/1ps
`include "hcr_defs.svh"
module hcr_host
    import hcr_pkg::*;
(
    // Link to the hub
    hcr_if.host              LNK,
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // Register port
    input  wire logic [2:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA
);
    hcr_host_st_t st_reg;
    logic [15:0]  req_reg;
    logic [15:0]  val_reg;
    logic [15:0]  idx_reg;
    logic [15:0]  len_reg;
    logic [7:0]   buf_reg [`HCR_DESC_MAX];
    logic [4:0]   nbytes_reg;
    logic [4:0]   ptr_reg;
    logic         setup_reg;
    logic         dv_reg;
    logic [7:0]   db_reg;
    logic         status_reg;
    logic         busy_reg;
    hcr_res_t     res_reg;

    assign LNK.setup       = setup_reg;
    assign LNK.bm_req_type = req_reg[7:0];
    assign LNK.b_request   = req_reg[15:8];
    assign LNK.w_value     = val_reg;
    assign LNK.w_index     = idx_reg;
    assign LNK.w_length    = len_reg;
    assign LNK.data_valid  = dv_reg;
    assign LNK.data_byte   = db_reg;
    assign LNK.status      = status_reg;

    // Setup fields are frozen while a transfer runs
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            req_reg <= 16'h0000;
            val_reg <= 16'h0000;
            idx_reg <= 16'h0000;
            len_reg <= 16'h0000;
        end else if (WR && !busy_reg) begin
            case (ADDR)
                `HCR_A_REQ:    req_reg <= WDATA;
                `HCR_A_VALUE:  val_reg <= WDATA;
                `HCR_A_INDEX:  idx_reg <= WDATA;
                `HCR_A_LENGTH: len_reg <= WDATA;
                default: ;
            endcase
        end
    end

    // Bytes sent need not match wLength
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            nbytes_reg <= 5'h00;
        end else if (WR && !busy_reg && ADDR == `HCR_A_CTRL && WDATA[1]) begin
            nbytes_reg <= 5'h00;
        end else if (WR && !busy_reg && ADDR == `HCR_A_DATA && nbytes_reg != 5'h10) begin
            buf_reg[nbytes_reg[3:0]] <= WDATA[7:0];
            nbytes_reg               <= nbytes_reg + 5'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_reg     <= HS_IDLE;
            busy_reg   <= 1'b0;
            res_reg    <= RES_OK;
            ptr_reg    <= 5'h00;
            setup_reg  <= 1'b0;
            dv_reg     <= 1'b0;
            db_reg     <= 8'h00;
            status_reg <= 1'b0;
        end else begin
            setup_reg  <= 1'b0;
            dv_reg     <= 1'b0;
            status_reg <= 1'b0;
            case (st_reg)
                HS_IDLE: begin
                    if (WR && ADDR == `HCR_A_CTRL && WDATA[0]) begin
                        setup_reg <= 1'b1;
                        busy_reg  <= 1'b1;
                        ptr_reg   <= 5'h00;
                        st_reg    <= HS_DATA;
                    end
                end
                HS_DATA: begin
                    if (LNK.resp_valid) begin
                        res_reg  <= LNK.resp_code;
                        busy_reg <= 1'b0;
                        st_reg   <= HS_IDLE;
                    end else if (ptr_reg != nbytes_reg) begin
                        dv_reg  <= 1'b1;
                        db_reg  <= buf_reg[ptr_reg[3:0]];
                        ptr_reg <= ptr_reg + 5'h01;
                    end else begin
                        status_reg <= 1'b1;
                        st_reg     <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (LNK.resp_valid) begin
                        res_reg  <= LNK.resp_code;
                        busy_reg <= 1'b0;
                        st_reg   <= HS_IDLE;
                    end
                end
                default: begin
                    st_reg <= HS_IDLE;
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            RDATA <= 16'h0000;
        end else if (RD && ADDR == `HCR_A_STAT) begin
            RDATA <= {7'h00, nbytes_reg, 1'b0, res_reg, busy_reg};
        end else if (RD && ADDR <= `HCR_A_LENGTH) begin
            RDATA <= ADDR == `HCR_A_REQ ? req_reg : ADDR == `HCR_A_VALUE ? val_reg :
                     ADDR == `HCR_A_INDEX ? idx_reg : len_reg;
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule

// ---- testbench/hcr_link_checker.sv ----
// Assertions on the link between the host end and the hub end
`timescale 1ns/1ps
module hcr_link_checker
    import hcr_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // Link signals
    input wire logic        setup,
    input wire logic [7:0]  bm_req_type,
    input wire logic [7:0]  b_request,
    input wire logic [15:0] w_value,
    input wire logic [15:0] w_index,
    input wire logic [15:0] w_length,
    input wire logic        data_valid,
    input wire logic        status,
    input wire logic        resp_valid,
    input wire hcr_res_t    resp_code
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Setup fields still stand with the answer
    wire logic pf = resp_valid && bm_req_type == 8'h23 && b_request == 8'h03;
    wire logic hr = resp_valid && bm_req_type == 8'h20;
    a_resp_after_status: assert property (status |-> ##1 (resp_valid ##1 !resp_valid))
        else $error("no single answer");
    a_stop_len_err: assert property (resp_valid && b_request == 8'h0b && w_length != 16'h0
        |-> resp_code == RES_REQ_ERR) else $error("stop length taken");
    a_desc_index_err: assert property (hr && b_request == 8'h07 && w_index != 16'h0
        |-> resp_code == RES_REQ_ERR) else $error("index taken");
    a_desc_len_err: assert property (hr && b_request == 8'h07 && w_length > 16'h10
        |-> resp_code == RES_REQ_ERR) else $error("long descriptor taken");
    a_hub_sel_err: assert property (hr && b_request == 8'h03 && w_value > 16'h1
        |-> resp_code == RES_REQ_ERR) else $error("hub selector taken");
    a_port_num_err: assert property (pf && (w_index[7:0] == 8'h0 || w_index[7:0] > 8'h4)
        |-> resp_code == RES_REQ_ERR) else $error("port number taken");
    a_test_sel_err: assert property (pf && w_value == 16'h15 && (w_index[15:8] == 8'h0
        || w_index[15:8] > 8'h5) |-> resp_code == RES_REQ_ERR) else $error("test selector taken");
    a_ind_sel_err: assert property (pf && w_value == 16'h16 && w_index[15:8] > 8'h3
        |-> resp_code == RES_REQ_ERR) else $error("indicator taken");
    c_port_ok: cover property (pf && resp_code == RES_OK);
    c_err: cover property (status ##1 (resp_valid && resp_code == RES_REQ_ERR));
    c_data: cover property (setup ##1 data_valid ##1 data_valid);
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench joining the host end to the hub end
`timescale 1ns/1ps
module testbench
    import hcr_pkg::*;
;
    logic        clk, reset_n, wstb, rstb, ttr, tts;
    logic [2:0]  addr;
    logic [15:0] wdata, rdata, rv;
    logic [3:0]  pen, pdis, pres, pwr, rdrv, susp, ten, ccon, csus, crst, daddr;
    logic [7:0]  tsel, ind, ddata;
    int          num_errors = 0;
    int          check_count = 0;
    hcr_if lnk();
    hcr_host u_hcr_host (.LNK(lnk), .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wstb),
        .RD(rstb), .RDATA(rdata));
    // Change bits are never acknowledged here; only the hub reset clears them
    hcr_device u_hcr_device (.LNK(lnk), .CLK(clk), .RESET_N(reset_n), .PORT_ENABLED(pen),
        .PORT_DISCONNECT(pdis), .PORT_RESUME(pres), .CLR_C_RESET(4'h0), .CLR_C_CONN(4'h0), .CLR_C_SUSP(4'h0),
        .PORT_POWER(pwr), .PORT_RESET_DRV(rdrv), .PORT_SUSPEND(susp), .PORT_ENABLE_SET(), .PORT_TEST_EN(ten),
        .TEST_SEL(tsel), .IND_SEL(ind), .C_PORT_RESET(crst), .C_PORT_CONN(ccon), .C_PORT_SUSP(csus),
        .TT_RESET(ttr), .TT_STOPPED(tts), .DESC_ADDR(daddr), .DESC_DATA(ddata), .DESC_UPDATED());
    hcr_link_checker u_hcr_link_checker (.CLK(clk), .RESET_N(reset_n), .setup(lnk.setup),
        .bm_req_type(lnk.bm_req_type), .b_request(lnk.b_request), .w_value(lnk.w_value), .w_index(lnk.w_index),
        .w_length(lnk.w_length), .data_valid(lnk.data_valid), .status(lnk.status), .resp_valid(lnk.resp_valid),
        .resp_code(lnk.resp_code));
    task automatic chk(input logic [15:0] g, e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wstb  <= 1'b1;
        @(posedge clk);
        wstb  <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 rv = rdata;
    endtask
    // Byte k of an l-byte write is l*16+k
    task automatic xfer(input logic [15:0] q, v, i, l, input int n, input hcr_res_t e);
        wr(3'h5, 16'h0002);
        wr(3'h0, q);
        wr(3'h1, v);
        wr(3'h2, i);
        wr(3'h3, l);
        for (int k = 0; k < n; k++)
            wr(3'h4, 16'(l * 16 + k));
        wr(3'h5, 16'h0001);
        rv = 16'h0001;
        for (int k = 0; k < 100 && rv[0] !== 1'b0; k++)
            rd(3'h6);
        chk(16'(rv[2:0]), 16'({e, 1'b0}));
    endtask
    task automatic pf(input logic [15:0] v, i, input hcr_res_t e);
        xfer(16'h323, v, i, 16'h0, 0, e);
    endtask
    task automatic t_power;
        pf(16'h8, 16'h1, RES_OK);
        pf(16'h8, 16'h1, RES_OK);
        pf(16'h8, 16'h5, RES_REQ_ERR);
        pf(16'h8, 16'h0, RES_REQ_ERR);
        chk(16'(pwr), 16'h1);
    endtask
    task automatic t_reset;
        pf(16'h4, 16'h1, RES_OK);
        chk(16'(rdrv), 16'h1);
        pf(16'h4, 16'h2, RES_OK);
        repeat (60) @(posedge clk);
        #1 chk(16'(crst), 16'h1);
    endtask
    task automatic t_desc;
        xfer(16'h720, 16'h2900, 16'h0, 3, 3, RES_OK);
        xfer(16'h720, 16'h2900, 16'h0, 4, 3, RES_REQ_ERR);
        xfer(16'h720, 16'h2900, 16'h1, 2, 2, RES_REQ_ERR);
        xfer(16'h720, 16'h2901, 16'h0, 1, 1, RES_REQ_ERR);
        repeat (2) @(posedge clk);
        #1 chk(16'(ddata), 16'h30);
    endtask
    task automatic t_stop;
        xfer(16'hb23, 16'h0, 16'h1, 1, 0, RES_REQ_ERR);
        xfer(16'hb23, 16'h0, 16'h1, 0, 0, RES_OK);
        xfer(16'h320, 16'h1, 16'h0, 0, 0, RES_OK);
        xfer(16'h320, 16'h2, 16'h0, 0, 0, RES_REQ_ERR);
        chk(16'(tts), 16'h1);
        ttr <= 1'b1;
        @(posedge clk);
        ttr <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(16'(tts), 16'h0);
    endtask
    task automatic t_test;
        @(posedge clk);
        pen <= 4'h1;
        pf(16'h15, 16'h402, RES_REQ_ERR);
        pf(16'h2, 16'h1, RES_OK);
        pf(16'h2, 16'h3, RES_OK);
        chk(16'(susp), 16'h1);
        pf(16'h15, 16'h2, RES_REQ_ERR);
        pf(16'h15, 16'h602, RES_REQ_ERR);
        pf(16'h16, 16'h403, RES_REQ_ERR);
        pf(16'h16, 16'h203, RES_OK);
        chk(16'(ind), 16'h20);
        pf(16'h15, 16'h402, RES_OK);
        chk(16'({ten, tsel}), 16'h204);
        @(posedge clk);
        pdis <= 4'h1;
        pres <= 4'h1;
        @(posedge clk);
        pdis <= 4'h0;
        pres <= 4'h0;
        repeat (2) @(posedge clk);
        #1 chk(16'({ccon, csus}), 16'h11);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        pf(16'h8, 16'h2, RES_OK);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {reset_n, wstb, rstb, ttr, addr, wdata, pen, pdis, pres, daddr} = '0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_power;
        t_reset;
        t_desc;
        t_stop;
        t_test;
        end_of_test;
    end
    initial begin
        #100000;
        num_errors++;
        end_of_test;
    end
endmodule
